//--- byte_add_flags.sv
// add-to-accumulator datapath with apb register access
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - The selected source byte is added to the accumulator and the low eight sum bits are written back.
// - Carry is set on a carry out of bit 7 and half-carry on a carry out of bit 3, each cleared otherwise.
// - Signed wrap is set when exactly one of the carries out of bit 6 and bit 7 occurs, else cleared.
// - Opcode 00101rrr picks a bank register, 0010011i uses register 0 or 1 as a pointer, 00100100 is immediate.
// - The direct form is two bytes and adds the byte stored at the address held in the second byte.
// - The immediate form is two bytes and adds the second byte itself.
module byte_add_flags (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [7:0] mem_q [baf_pkg::BAF_MEM_DEPTH];
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic carry_q;
    logic carry_d;
    logic half_q;
    logic half_d;
    logic wrap_q;
    logic wrap_d;
    logic [1:0] bank_q;
    logic [1:0] bank_d;
    logic [1:0] len_q;
    logic [1:0] len_d;
    logic badop_q;
    logic badop_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic slverr_q;
    logic slverr_d;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;

    logic [7:0] opc;
    logic [7:0] opnd;
    baf_pkg::baf_src_t src_kind;
    logic [7:0] pointer_reg;
    logic [7:0] src_byte;
    logic [7:0] sum;
    logic carry_out;
    logic half_carry_out;
    logic wrap_out;
    logic setup;
    logic access;
    logic is_mem;
    logic [7:0] mem_idx;

    // classify an opcode into its source form
    function automatic baf_pkg::baf_src_t decode_src(input logic [7:0] op);
        baf_pkg::baf_src_t k;
        k = baf_pkg::BAF_SRC_NONE;
        if (op[7:3] == baf_pkg::BAF_OPC_BANK) begin
            k = baf_pkg::BAF_SRC_BANK;
        end else if (op[7:1] == baf_pkg::BAF_OPC_PTR) begin
            k = baf_pkg::BAF_SRC_PTR;
        end else if (op == baf_pkg::BAF_OPC_DIRECT) begin
            k = baf_pkg::BAF_SRC_DIRECT;
        end else if (op == baf_pkg::BAF_OPC_IMM) begin
            k = baf_pkg::BAF_SRC_IMM;
        end
        return k;
    endfunction

    // internal-memory address of a bank register
    function automatic logic [7:0] bank_addr(
        input logic [1:0] bank,
        input logic [2:0] idx
    );
        return {3'h0, bank, idx};
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = penable;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;
    assign opc = pwdata[baf_pkg::BAF_OPC_LSB +: 8];
    assign opnd = pwdata[baf_pkg::BAF_OPND_LSB +: 8];
    assign is_mem = paddr[11:10] == baf_pkg::BAF_MEM_BASE[11:10];
    assign mem_idx = paddr[9:2];

    // operand selection
    always_comb begin
        src_kind = decode_src(opc);
        pointer_reg = mem_q[bank_addr(bank_q, {2'h0, opc[0]})];
        case (src_kind)
            baf_pkg::BAF_SRC_BANK: begin
                src_byte = mem_q[bank_addr(bank_q, opc[2:0])];
            end
            baf_pkg::BAF_SRC_PTR: begin
                src_byte = mem_q[pointer_reg];
            end
            baf_pkg::BAF_SRC_DIRECT: begin
                src_byte = mem_q[opnd];
            end
            baf_pkg::BAF_SRC_IMM: begin
                src_byte = opnd;
            end
            default: begin
                src_byte = 8'h00;
            end
        endcase
    end

    baf_adder u_adder (
        .acc(acc_q),
        .src(src_byte),
        .sum(sum),
        .carry_out(carry_out),
        .half_carry_out(half_carry_out),
        .wrap_out(wrap_out)
    );

    // register writes and instruction execution at the access edge
    always_comb begin
        acc_d = acc_q;
        carry_d = carry_q;
        half_d = half_q;
        wrap_d = wrap_q;
        bank_d = bank_q;
        len_d = len_q;
        badop_d = badop_q;
        mem_we = 1'b0;
        mem_waddr = mem_idx;
        mem_wdata = pwdata[7:0];
        if (access && pwrite) begin
            if (paddr == baf_pkg::BAF_ACC_OFS) begin
                acc_d = pwdata[7:0];
            end else if (paddr == baf_pkg::BAF_FLAGS_OFS) begin
                carry_d = pwdata[baf_pkg::BAF_CARRY_BIT];
                half_d = pwdata[baf_pkg::BAF_HALF_BIT];
                wrap_d = pwdata[baf_pkg::BAF_WRAP_BIT];
                bank_d = pwdata[baf_pkg::BAF_BANK_LSB +: 2];
            end else if (paddr == baf_pkg::BAF_INSTR_OFS) begin
                if (src_kind == baf_pkg::BAF_SRC_NONE) begin
                    badop_d = 1'b1;
                end else begin
                    badop_d = 1'b0;
                    acc_d = sum;
                    carry_d = carry_out;
                    half_d = half_carry_out;
                    wrap_d = wrap_out;
                    if (src_kind == baf_pkg::BAF_SRC_DIRECT ||
                        src_kind == baf_pkg::BAF_SRC_IMM) begin
                        len_d = baf_pkg::BAF_LEN_TWO;
                    end else begin
                        len_d = baf_pkg::BAF_LEN_ONE;
                    end
                end
            end else if (is_mem) begin
                mem_we = 1'b1;
            end
        end
    end

    // read data and error are captured in the setup cycle
    always_comb begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (setup) begin
            prdata_d = 32'h0000_0000;
            slverr_d = 1'b0;
            if (paddr == baf_pkg::BAF_ACC_OFS) begin
                prdata_d[7:0] = acc_q;
            end else if (paddr == baf_pkg::BAF_FLAGS_OFS) begin
                prdata_d[baf_pkg::BAF_CARRY_BIT] = carry_q;
                prdata_d[baf_pkg::BAF_HALF_BIT] = half_q;
                prdata_d[baf_pkg::BAF_WRAP_BIT] = wrap_q;
                prdata_d[baf_pkg::BAF_BANK_LSB +: 2] = bank_q;
            end else if (paddr == baf_pkg::BAF_INSTR_OFS) begin
                prdata_d = 32'h0000_0000;
            end else if (paddr == baf_pkg::BAF_STATUS_OFS) begin
                prdata_d[baf_pkg::BAF_LEN_LSB +: 2] = len_q;
                prdata_d[baf_pkg::BAF_BADOP_BIT] = badop_q;
            end else if (is_mem) begin
                prdata_d[7:0] = mem_q[mem_idx];
            end else begin
                slverr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_q <= baf_pkg::BAF_ACC_RST;
            carry_q <= baf_pkg::BAF_FLAGS_RST[baf_pkg::BAF_CARRY_BIT];
            half_q <= baf_pkg::BAF_FLAGS_RST[baf_pkg::BAF_HALF_BIT];
            wrap_q <= baf_pkg::BAF_FLAGS_RST[baf_pkg::BAF_WRAP_BIT];
            bank_q <= baf_pkg::BAF_FLAGS_RST[baf_pkg::BAF_BANK_LSB +: 2];
            len_q <= baf_pkg::BAF_LEN_RST;
            badop_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            carry_q <= carry_d;
            half_q <= half_d;
            wrap_q <= wrap_d;
            bank_q <= bank_d;
            len_q <= len_d;
            badop_q <= badop_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    // internal memory has no reset; software initialises it
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_q[mem_waddr] <= mem_wdata;
        end
    end
endmodule // byte_add_flags

//--- baf_pkg.sv
// constants for the byte add datapath and its apb register map
package baf_pkg;
    localparam int unsigned BAF_DATA_W = 32;
    localparam int unsigned BAF_ADDR_W = 12;
    localparam int unsigned BAF_MEM_DEPTH = 256;

    // register byte addresses
    localparam logic [11:0] BAF_ACC_OFS = 12'h000;
    localparam logic [11:0] BAF_FLAGS_OFS = 12'h004;
    localparam logic [11:0] BAF_INSTR_OFS = 12'h008;
    localparam logic [11:0] BAF_STATUS_OFS = 12'h00c;
    localparam logic [11:0] BAF_MEM_BASE = 12'h400;

    // flags register fields
    localparam int unsigned BAF_CARRY_BIT = 7;
    localparam int unsigned BAF_HALF_BIT = 6;
    localparam int unsigned BAF_BANK_LSB = 3;
    localparam int unsigned BAF_WRAP_BIT = 2;

    // instruction register fields
    localparam int unsigned BAF_OPC_LSB = 0;
    localparam int unsigned BAF_OPND_LSB = 8;

    // status register fields
    localparam int unsigned BAF_LEN_LSB = 0;
    localparam int unsigned BAF_BADOP_BIT = 4;

    // reset values
    localparam logic [7:0] BAF_ACC_RST = 8'h00;
    localparam logic [7:0] BAF_FLAGS_RST = 8'h00;
    localparam logic [1:0] BAF_LEN_RST = 2'h0;

    // opcode patterns
    localparam logic [4:0] BAF_OPC_BANK = 5'h05;
    localparam logic [6:0] BAF_OPC_PTR = 7'h13;
    localparam logic [7:0] BAF_OPC_DIRECT = 8'h25;
    localparam logic [7:0] BAF_OPC_IMM = 8'h24;

    localparam logic [1:0] BAF_LEN_ONE = 2'h1;
    localparam logic [1:0] BAF_LEN_TWO = 2'h2;

    typedef enum logic [2:0] {
        BAF_SRC_BANK,
        BAF_SRC_PTR,
        BAF_SRC_DIRECT,
        BAF_SRC_IMM,
        BAF_SRC_NONE
    } baf_src_t;
endpackage

//--- baf_adder.sv
// 8-bit adder with carry, half-carry and signed-wrap outputs
`timescale 1ns/1ps
module baf_adder (
    input wire logic [7:0] acc,
    input wire logic [7:0] src,
    output logic [7:0] sum,
    output logic carry_out,
    output logic half_carry_out,
    output logic wrap_out
);
    logic [4:0] low_nib;
    logic [7:0] low7;
    logic [8:0] full;

    always_comb begin
        low_nib = {1'b0, acc[3:0]} + {1'b0, src[3:0]};
        low7 = {1'b0, acc[6:0]} + {1'b0, src[6:0]};
        full = {1'b0, acc} + {1'b0, src};
        sum = full[7:0];
        carry_out = full[8];
        half_carry_out = low_nib[4];
        wrap_out = full[8] ^ low7[7];
    end
endmodule // baf_adder

//--- byte_add_flags_chk.sv
// assertion checker on the byte add datapath apb ports
`timescale 1ns/1ps
module baf_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic wr, rd, ra, rf, rs, wf, wi, wd, wb;
    logic [7:0] a_q, a_d, b_q, b_d;
    logic [8:0] s;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign ra = rd && paddr == 12'h000;
    assign rf = rd && paddr == 12'h004;
    assign rs = rd && paddr == 12'h00c;
    assign wf = wr && paddr == 12'h004;
    assign wi = wr && paddr == 12'h008 && pwdata[7:0] == 8'h24;
    assign wd = wr && paddr == 12'h008 && pwdata[7:1] == 7'h12;
    assign wb = wr && paddr == 12'h008 && pwdata[7:4] != 4'h2;
    assign s = {1'b0, a_q} + {1'b0, b_q};
    // last accumulator write and last immediate operand
    always_comb begin
        a_d = wr && paddr == 12'h000 ? pwdata[7:0] : a_q;
        b_d = wi ? pwdata[15:8] : b_q;
    end
    always_ff @(posedge clk) {a_q, b_q} <= {a_d, b_d};
    a_acc_sum: assert property (ra && $past(wi, 3) |->
        prdata[7:0] == s[7:0]) else $error("accumulator not the sum");
    a_carry_half: assert property (rf && $past(wi, 6) |->
        prdata[7:6] == {s[8], s[4] ^ a_q[4] ^ b_q[4]}) else $error("carry");
    a_signed_wrap: assert property (rf && $past(wi, 6) |->
        prdata[2] == (s[8] ^ s[7] ^ a_q[7] ^ b_q[7])) else $error("wrap");
    a_len_two: assert property (rs && $past(wd, 9) |->
        prdata[1:0] == 2'h2) else $error("two byte length wrong");
    a_bad_opcode: assert property (rs && $past(wb, 9) |->
        prdata[4]) else $error("bad opcode not flagged");
    a_bank_kept: assert property (rf && $past(wf, 9) |->
        prdata[4:3] == $past(pwdata[4:3], 9)) else $error("bank lost");
    a_zero_wait: assert property (psel && !penable ##1 penable |->
        pready) else $error("no ready in access phase");
    a_unmapped_err: assert property (psel && penable && paddr inside
        {[12'h010:12'h3fc]} |-> pslverr) else $error("no slave error");
endmodule // baf_chk

//--- test_byte_add_flags.sv
// self-checking bench for the byte add datapath
`timescale 1ns/1ps
module test_byte_add_flags;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int miscompares, num_checks, cyc, acc, fl, len, bad, v;
    int mem [256];
    byte_add_flags byte_add_flags_i (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic conclude();
        miscompares += cyc >= 10000;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) conclude();
    end
    task automatic chk(input string n, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input int d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 32'(d)};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge clk);
    endtask
    task automatic exec(input int op, input int b);
        int r, src;
        r = fl / 8 % 4 * 8;
        xfer(1'b1, 12'h008, b * 256 + op);
        src = op == 8'h24 ? b : op == 8'h25 ? mem[b] : -1;
        if (op / 2 == 8'h13) src = mem[mem[r + op % 2]];
        if (op / 8 == 8'h05) src = mem[r + op % 8];
        bad = src < 0;
        if (src >= 0) begin
            len = op < 8'h26 ? 2 : 1;
            v = acc + src;
            fl = fl & 8'h18 | v / 256 * 128;
            fl = fl | (acc % 16 + src % 16) / 16 * 64;
            fl = fl | (v / 256 ^ (acc % 128 + src % 128) / 128) * 4;
            acc = v % 256;
        end
        xfer(1'b0, 12'h000, 0);
        chk("acc", rdat, acc);
        xfer(1'b0, 12'h004, 0);
        chk("flags", rdat, fl);
        xfer(1'b0, 12'h00c, 0);
        chk("status", rdat, bad * 16 + len);
    endtask
    initial begin
        {srst, psel, penable, pwrite} = 4'h8;
        {paddr, pwdata} = '0;
        v = $urandom(32'h0946);
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        exec(8'h30, 0);
        // first pass is c3 plus aa: 6d, carry and wrap set, half clear
        for (int i = 0; i < 40; i++) begin
            acc = i == 0 ? 8'hc3 : $urandom % 256;
            xfer(1'b1, 12'h000, acc);
            exec(8'h24, i == 0 ? 8'haa : $urandom % 256);
        end
        exec(8'h23, 8'h5a);
        for (int i = 0; i < 256; i++) begin
            mem[i] = $urandom % 256;
            xfer(1'b1, 12'h400 + 12'(i * 4), mem[i]);
        end
        for (int i = 0; i < 80; i++) begin
            v = $urandom;
            fl = v & 8'hdc;
            xfer(1'b1, 12'h004, v);
            exec(8'h25 + $urandom % 11, $urandom % 256);
        end
        xfer(1'b0, 12'h010, 0);
        chk("unmapped", 32'(rerr), 32'h1);
        xfer(1'b1, 12'h00c, 32'hff);
        chk("status write", 32'(rerr), 32'h0);
        exec(8'h30, 0);
        conclude();
    end
endmodule // test_byte_add_flags
bind byte_add_flags baf_chk baf_chk_i (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
